// file: rtl/dtc_edge.sv
// Purpose: synchronise one counter input pin and detect its transitions
// Assumes: pin is asynchronous to the system clock
// Notes:   strobes are suppressed until the pipeline holds real pin samples
`default_nettype none

module dtc_edge
	import dtc_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_pin,
	dtc_edge_if.src    edge_o
);
	dtc_edge_state_t st;
	dtc_edge_state_t next_st;

	// ==================================================
	// two-stage synchroniser, then edge compare
	always_comb begin
		next_st       = st;
		next_st.sync1 = i_pin;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
		next_st.rdy   = {st.rdy[1:0], 1'b1};
		// no edge before prev holds a real sample, so reset cannot fake one
		next_st.rise  = st.rdy[2] & st.sync2 & ~st.prev;
		next_st.fall  = st.rdy[2] & ~st.sync2 & st.prev;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign edge_o.rise = st.rise;
	assign edge_o.fall = st.fall;
endmodule

`default_nettype wire

// file: rtl/dtc_edge_if.sv
// Purpose: carries detected pin transitions from the input stage to the counters
// Assumes: single system clock
// Notes:   both strobes are one-cycle pulses
`default_nettype none

interface dtc_edge_if;
	logic rise;
	logic fall;
	modport src (output rise, output fall);
	modport dst (input rise, input fall);
endinterface

`default_nettype wire

// file: rtl/dtc_pkg.sv
// Purpose: shared constants and state types for the dual timer/event counter
// Assumes: 8-bit data-memory style register port, one system clock
// Notes:   counter reset values are plain defaults; control resets to edge bit set
`default_nettype none

package dtc_pkg;
	// ==================================================
	// register offsets
	localparam logic [7:0] ADDR_A_VALUE = 8'h0d;
	localparam logic [7:0] ADDR_A_CTL   = 8'h0e;
	localparam logic [7:0] ADDR_B_HIGH  = 8'h0f;
	localparam logic [7:0] ADDR_B_LOW   = 8'h10;
	localparam logic [7:0] ADDR_B_CTL   = 8'h11;
	// ==================================================
	// control field layout
	localparam int         CTL_EDGE_BIT = 3;
	localparam int         CTL_RUN_BIT  = 4;
	localparam int         CTL_MODE_LSB = 6;
	localparam logic [7:0] CTL_RW_MASK  = 8'hd8;
	localparam logic [7:0] CTL_RESET    = 8'h08;
	localparam logic [1:0] MODE_EVENT   = 2'h1;
	localparam logic [1:0] MODE_TIMER   = 2'h2;
	localparam logic [1:0] MODE_PULSE   = 2'h3;
	// ==================================================
	// counts and reset values
	localparam logic [1:0]  PRESCALE_LAST = 2'h3;
	localparam logic [7:0]  A_ALL_ONES    = 8'hff;
	localparam logic [15:0] B_ALL_ONES    = 16'hffff;
	localparam logic [7:0]  A_RESET       = 8'h00;
	localparam logic [15:0] B_RESET       = 16'h0000;
	localparam logic [7:0]  DATA_RESET    = 8'h00;
	// ==================================================
	// state types
	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [2:0] rdy;
		logic       rise;
		logic       fall;
	} dtc_edge_state_t;

	typedef struct packed {
		logic [1:0]  prescale;
		logic        pre_tick;
		logic [7:0]  a_cnt;
		logic [7:0]  a_pre;
		logic [7:0]  a_ctl;
		logic        a_meas;
		logic [15:0] b_cnt;
		logic [15:0] b_pre;
		logic [7:0]  b_ctl;
		logic        b_meas;
		logic [7:0]  lbuf;
		logic [7:0]  rdata;
		logic        a_flag;
		logic        b_flag;
		logic        a_irq;
		logic        b_irq;
		logic        wake;
	} dtc_state_t;
endpackage

`default_nettype wire

// file: rtl/dtc_top.sv
// Purpose: 8-bit and 16-bit count-up timer/event counters with preload
// Assumes: register strobes synchronous to the system clock domain; pins may be asynchronous
// Notes:   read data appears one cycle after the read strobe
`default_nettype none

module dtc_top
	import dtc_pkg::*;
(
	input  wire logic       I_SYS_CLK,
	input  wire logic       I_RST_N,
	input  wire logic [7:0] I_ADDR,
	input  wire logic       I_WR_EN,
	input  wire logic       I_RD_EN,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_A_PIN,
	input  wire logic       I_B_PIN,
	input  wire logic       I_A_IRQ_EN,
	input  wire logic       I_B_IRQ_EN,
	input  wire logic       I_A_FLAG_CLR,
	input  wire logic       I_B_FLAG_CLR,
	output logic      [7:0] O_RDATA,
	output logic            O_A_FLAG,
	output logic            O_B_FLAG,
	output logic            O_A_IRQ,
	output logic            O_B_IRQ,
	output logic            O_WAKE
);
	dtc_state_t st;
	dtc_state_t next_st;
	dtc_edge_if a_edge ();
	dtc_edge_if b_edge ();

	logic       a_blk;
	logic       b_blk;
	logic       a_adv;
	logic       b_adv;
	logic       a_ovf;
	logic       b_ovf;
	logic [1:0] a_pw;
	logic [1:0] b_pw;
	logic       wr_a_val;
	logic       wr_b_high;
	logic       wr_b_low;

	// ==================================================
	// input stages
	dtc_edge u_a_edge (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RST_N),
		.i_pin   (I_A_PIN),
		.edge_o  (a_edge)
	);

	dtc_edge u_b_edge (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RST_N),
		.i_pin   (I_B_PIN),
		.edge_o  (b_edge)
	);

	// ==================================================
	// shared decode
	function automatic logic [7:0] ctl_view(input logic [7:0] c);
		ctl_view = c & CTL_RW_MASK;
	endfunction

	function automatic logic sel_edge(input logic [7:0] c, input logic r, input logic f);
		sel_edge = c[CTL_EDGE_BIT] ? f : r;
	endfunction

	// one count step for either counter
	function automatic logic advance(
		input logic [7:0] c,
		input logic       meas,
		input logic       r,
		input logic       f,
		input logic       tick,
		input logic       blk
	);
		logic [1:0] m;
		m = c[CTL_MODE_LSB +: 2];
		advance = 1'b0;
		if (c[CTL_RUN_BIT] && !blk) begin
			case (m)
				MODE_EVENT: advance = sel_edge(c, r, f);
				MODE_TIMER: advance = tick;
				MODE_PULSE: advance = meas & tick;
				default:    advance = 1'b0;
			endcase
		end
	endfunction

	// pulse width tracking: {next measuring, measurement done}
	function automatic logic [1:0] pw_step(
		input logic [7:0] c,
		input logic       meas,
		input logic       r,
		input logic       f
	);
		logic start;
		logic stop;
		start = sel_edge(c, r, f);
		stop  = c[CTL_EDGE_BIT] ? r : f;
		if (c[CTL_MODE_LSB +: 2] != MODE_PULSE || !c[CTL_RUN_BIT]) begin
			pw_step = 2'b00;
		end else if (meas && stop) begin
			pw_step = 2'b01;
		end else if (!meas && start) begin
			pw_step = 2'b10;
		end else begin
			pw_step = {meas, 1'b0};
		end
	endfunction

	// ==================================================
	// request qualifiers
	assign wr_a_val  = I_WR_EN && (I_ADDR == ADDR_A_VALUE);
	assign wr_b_high = I_WR_EN && (I_ADDR == ADDR_B_HIGH);
	assign wr_b_low  = I_WR_EN && (I_ADDR == ADDR_B_LOW);
	// a read may drop a tick; software is expected to tolerate that
	assign a_blk = I_RD_EN && (I_ADDR == ADDR_A_VALUE);
	assign b_blk = I_RD_EN && ((I_ADDR == ADDR_B_HIGH) || (I_ADDR == ADDR_B_LOW));
	assign a_adv = advance(st.a_ctl, st.a_meas, a_edge.rise, a_edge.fall, st.pre_tick, a_blk);
	assign b_adv = advance(st.b_ctl, st.b_meas, b_edge.rise, b_edge.fall, st.pre_tick, b_blk);
	assign a_ovf = a_adv && (st.a_cnt == A_ALL_ONES);
	assign b_ovf = b_adv && (st.b_cnt == B_ALL_ONES);
	assign a_pw  = pw_step(st.a_ctl, st.a_meas, a_edge.rise, a_edge.fall);
	assign b_pw  = pw_step(st.b_ctl, st.b_meas, b_edge.rise, b_edge.fall);

	// ==================================================
	// next state
	always_comb begin
		next_st = st;
		// free-running divide-by-four tick
		next_st.prescale = st.prescale + 2'h1;
		next_st.pre_tick = (st.prescale == PRESCALE_LAST);

		// counter a
		if (a_adv) begin
			if (a_ovf) begin
				next_st.a_cnt = st.a_pre;
			end else begin
				next_st.a_cnt = st.a_cnt + 8'h01;
			end
		end
		next_st.a_meas = a_pw[1];
		if (a_pw[0]) begin
			next_st.a_ctl[CTL_RUN_BIT] = 1'b0;
		end

		// counter b
		if (b_adv) begin
			if (b_ovf) begin
				next_st.b_cnt = st.b_pre;
			end else begin
				next_st.b_cnt = st.b_cnt + 16'h0001;
			end
		end
		next_st.b_meas = b_pw[1];
		if (b_pw[0]) begin
			next_st.b_ctl[CTL_RUN_BIT] = 1'b0;
		end

		// reads: registered data, high read also captures the low byte
		if (I_RD_EN) begin
			case (I_ADDR)
				ADDR_A_VALUE: next_st.rdata = st.a_cnt;
				ADDR_A_CTL:   next_st.rdata = ctl_view(st.a_ctl);
				ADDR_B_HIGH: begin
					next_st.rdata = st.b_cnt[15:8];
					next_st.lbuf  = st.b_cnt[7:0];
				end
				ADDR_B_LOW:   next_st.rdata = st.lbuf;
				ADDR_B_CTL:   next_st.rdata = ctl_view(st.b_ctl);
				default:      next_st.rdata = DATA_RESET;
			endcase
		end

		// writes win over hardware updates of the same cycle
		if (I_WR_EN) begin
			case (I_ADDR)
				ADDR_A_VALUE: begin
					next_st.a_pre = I_WDATA;
					if (!st.a_ctl[CTL_RUN_BIT]) begin
						next_st.a_cnt = I_WDATA;
					end
				end
				ADDR_A_CTL:   next_st.a_ctl = ctl_view(I_WDATA);
				ADDR_B_HIGH: begin
					next_st.b_pre = {I_WDATA, st.lbuf};
					if (!st.b_ctl[CTL_RUN_BIT]) begin
						next_st.b_cnt = {I_WDATA, st.lbuf};
					end
				end
				ADDR_B_LOW:   next_st.lbuf = I_WDATA;
				ADDR_B_CTL:   next_st.b_ctl = ctl_view(I_WDATA);
				default:      next_st.lbuf = next_st.lbuf;
			endcase
		end

		// request flags: an overflow in the clearing cycle still sets
		next_st.a_flag = a_ovf | (st.a_flag & ~I_A_FLAG_CLR);
		next_st.b_flag = b_ovf | (st.b_flag & ~I_B_FLAG_CLR);
		next_st.a_irq  = next_st.a_flag & I_A_IRQ_EN;
		next_st.b_irq  = next_st.b_flag & I_B_IRQ_EN;
		next_st.wake   = a_ovf | b_ovf;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st       <= '0;
			st.a_cnt <= A_RESET;
			st.a_pre <= A_RESET;
			st.b_cnt <= B_RESET;
			st.b_pre <= B_RESET;
			st.a_ctl <= CTL_RESET;
			st.b_ctl <= CTL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================
	// outputs
	assign O_RDATA  = st.rdata;
	assign O_A_FLAG = st.a_flag;
	assign O_B_FLAG = st.b_flag;
	assign O_A_IRQ  = st.a_irq;
	assign O_B_IRQ  = st.b_irq;
	assign O_WAKE   = st.wake;

	// ==================================================
	// checks
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	ctl_read_zero_a: assert property (
		I_RD_EN && !I_WR_EN && (I_ADDR == ADDR_B_CTL || I_ADDR == ADDR_A_CTL)
		|=> (O_RDATA[2:0] == 3'h0) && !O_RDATA[5])
		else $error("unused control bits read nonzero");

	a_reload_a: assert property (
		a_ovf && !wr_a_val |=> st.a_cnt == $past(st.a_pre))
		else $error("counter a did not reload on overflow");

	b_flag_set_a: assert property (
		b_ovf |=> O_B_FLAG && (O_B_IRQ == $past(I_B_IRQ_EN)))
		else $error("counter b overflow flag or irq wrong");

	timer_rate_a: assert property (
		a_adv && st.a_ctl[CTL_MODE_LSB +: 2] == MODE_TIMER |-> st.pre_tick ##1 !st.pre_tick [*3])
		else $error("timer mode not at clock over four");

	stop_hold_a: assert property (
		!st.b_ctl[CTL_RUN_BIT] && !wr_b_high |=> $stable(st.b_cnt))
		else $error("stopped counter b changed");

	stopped_load_a: assert property (
		wr_a_val && !st.a_ctl[CTL_RUN_BIT] |=> st.a_cnt == $past(I_WDATA) && st.a_pre == st.a_cnt)
		else $error("stopped write did not load counter a");

	b_pair_a: assert property (
		wr_b_low ##1 (!I_WR_EN && !I_RD_EN) ##1 wr_b_high
		|=> st.b_pre == {$past(I_WDATA), $past(I_WDATA, 3)})
		else $error("counter b preload pairing wrong");

	b_latch_a: assert property (
		I_RD_EN && !I_WR_EN && I_ADDR == ADDR_B_HIGH
		|=> O_RDATA == $past(st.b_cnt[15:8]) && st.lbuf == $past(st.b_cnt[7:0]))
		else $error("high read did not latch low byte");

	pw_end_a: assert property (
		a_pw[0] && !(I_WR_EN && I_ADDR == ADDR_A_CTL) |=> !st.a_ctl[CTL_RUN_BIT] && !st.a_meas)
		else $error("pulse end did not clear run");

	read_block_a: assert property (
		a_blk && !wr_a_val |=> $stable(st.a_cnt))
		else $error("counter a ticked during read");

	running_write_a: assert property (
		wr_a_val && st.a_ctl[CTL_RUN_BIT] && !a_adv |=> $stable(st.a_cnt))
		else $error("running write disturbed counter a");

	flag_clear_a: assert property (
		a_ovf && I_A_FLAG_CLR |=> O_A_FLAG)
		else $error("overflow lost against flag clear");

	// a missed wake pulse would leave a halted core asleep
	a_flag_set_a: assert property (
		a_ovf |=> O_A_FLAG && O_WAKE)
		else $error("counter a overflow did not flag or wake");

	wake_pulse_a: assert property (
		!a_ovf && !b_ovf |=> !O_WAKE)
		else $error("wake pulse without overflow");

	irq_gate_a: assert property (
		!I_A_IRQ_EN |=> !O_A_IRQ)
		else $error("counter a irq raised while disabled");

	run_hold_a: assert property (
		st.a_ctl[CTL_MODE_LSB +: 2] != MODE_PULSE && !(I_WR_EN && I_ADDR == ADDR_A_CTL)
		|=> $stable(st.a_ctl[CTL_RUN_BIT]))
		else $error("run bit of counter a changed by itself");

	pulse_idle_a: assert property (
		st.a_ctl[CTL_MODE_LSB +: 2] == MODE_PULSE && !st.a_meas && !wr_a_val |=> $stable(st.a_cnt))
		else $error("counter a counted outside a measurement");

	event_step_a: assert property (
		st.b_ctl[CTL_MODE_LSB +: 2] == MODE_EVENT && st.b_ctl[CTL_RUN_BIT] && !b_blk && !wr_b_high
		&& (st.b_ctl[CTL_EDGE_BIT] ? b_edge.fall : b_edge.rise) && st.b_cnt != B_ALL_ONES
		|=> st.b_cnt == $past(st.b_cnt) + 16'h0001)
		else $error("counter b missed an input edge");

	b_reload_a: assert property (
		b_ovf && !wr_b_high |=> st.b_cnt == $past(st.b_pre))
		else $error("counter b did not reload on overflow");
endmodule

`default_nettype wire

// file: tb/dtc_pin_model.sv
// Purpose: drives the two counter input pins the way an outside signal source would
// Assumes: called from the bench just after a rising clock edge
// Notes:   levels only change when the bench asks; widths are in system clocks
`default_nettype none

module dtc_pin_model (
	input  wire logic i_clk,
	output var  logic o_a_pin,
	output var  logic o_b_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================
	// pin levels
	initial begin
		o_a_pin = 1'b0;
		o_b_pin = 1'b0;
	end

	task automatic level(input int which, input logic v);
		if (which == 0) begin
			o_a_pin = v;
		end else begin
			o_b_pin = v;
		end
	endtask

	// each level is held several clocks so the input synchroniser never misses it
	task automatic pulses(input int which, input int n, input int hi, input int lo);
		repeat (n) begin
			level(which, 1'b1);
			repeat (hi) @(posedge i_clk);
			#1;
			level(which, 1'b0);
			repeat (lo) @(posedge i_clk);
			#1;
		end
	endtask
endmodule

`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the dual timer/event counter
// Assumes: inputs change 1 ns after the rising clock edge
// Notes:   counts read near a prescaler tick are checked within one tick
`default_nettype none

module tb
	import dtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==================================================
	// stimulus and observed signals
	logic        clk          = 1'b0;
	logic        rst_n        = 1'b0;
	logic [7:0]  addr         = 8'h00;
	logic [7:0]  wdata        = 8'h00;
	logic        wr_en        = 1'b0;
	logic        rd_en        = 1'b0;
	logic        a_en         = 1'b0;
	logic        b_en         = 1'b0;
	logic        a_clr        = 1'b0;
	logic        b_clr        = 1'b0;
	logic        a_pin;
	logic        b_pin;
	logic [7:0]  rdata;
	logic        a_flag;
	logic        b_flag;
	logic        a_irq;
	logic        b_irq;
	logic        wake;
	logic [31:0] seed         = 32'hb587;
	int          fails        = 0;
	int          total_checks = 0;
	int          cyc          = 0;
	int          wakes        = 0;

	always #25 clk = ~clk;

	dtc_pin_model dtc_pin_model_inst (.i_clk(clk), .o_a_pin(a_pin), .o_b_pin(b_pin));

	dtc_top dtc_top_inst (
		.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WR_EN(wr_en), .I_RD_EN(rd_en),
		.I_WDATA(wdata), .I_A_PIN(a_pin), .I_B_PIN(b_pin), .I_A_IRQ_EN(a_en), .I_B_IRQ_EN(b_en),
		.I_A_FLAG_CLR(a_clr), .I_B_FLAG_CLR(b_clr), .O_RDATA(rdata), .O_A_FLAG(a_flag),
		.O_B_FLAG(b_flag), .O_A_IRQ(a_irq), .O_B_IRQ(b_irq), .O_WAKE(wake)
	);

	// ==================================================
	// helpers and reference model
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// up-counter that reloads from preload when it passes all ones
	function automatic int ev_model(input int c, input int p, input int n, input int top);
		for (int i = 0; i < n; i++) c = (c == top) ? p : c + 1;
		return c;
	endfunction

	task automatic stop_test();
		if (fails == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk) #1;
		wr_en = 1'b0;
		@(posedge clk) #1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		addr = a;
		rd_en = 1'b1;
		@(posedge clk) #1;
		rd_en = 1'b0;
		d = rdata;
		@(posedge clk) #1;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	task automatic rd_b(input int e);
		rdchk(ADDR_B_HIGH, 8'(e >> 8));
		rdchk(ADDR_B_LOW, 8'(e));
	endtask

	task automatic clr_flags();
		a_clr = 1'b1;
		b_clr = 1'b1;
		@(posedge clk) #1;
		a_clr = 1'b0;
		b_clr = 1'b0;
		@(posedge clk) #1;
	endtask

	// bounded wait for the counter a request flag
	task automatic wait_a(input int lim);
		int n;
		n = 0;
		while (a_flag !== 1'b1 && n < lim) begin
			@(posedge clk) #1;
			n++;
		end
		chk({7'h0, n < lim}, 8'h01);
	endtask

	// ==================================================
	// cycle ceiling and wake-up pulse count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake === 1'b1) begin
			wakes <= wakes + 1;
		end
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end

	// ==================================================
	// scenarios
	initial begin
		logic [7:0] r;
		logic [7:0] hi;
		logic [7:0] lo;
		int         n;
		int         w0;
		int         exp;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk) #1;
		rdchk(ADDR_A_CTL, CTL_RESET);
		rdchk(ADDR_B_CTL, CTL_RESET);
		rdchk(ADDR_A_VALUE, A_RESET);
		rdchk(8'h20, DATA_RESET);
		// every mode on both controls, run kept low, loose bits set at random
		for (int m = 0; m < 8; m++) begin
			r = rnd();
			r = {m[1:0], r[5], 1'b0, r[3:0]};
			wr(m[2] ? ADDR_B_CTL : ADDR_A_CTL, r);
			rdchk(m[2] ? ADDR_B_CTL : ADDR_A_CTL, r & 8'hc8);
		end
		r = rnd();
		wr(ADDR_A_VALUE, r);
		rdchk(ADDR_A_VALUE, r);
		lo = rnd();
		hi = rnd();
		wr(ADDR_B_LOW, lo);
		wr(ADDR_B_HIGH, hi);
		rdchk(ADDR_B_HIGH, hi);
		wr(ADDR_B_LOW, ~lo);
		rdchk(ADDR_B_HIGH, hi);
		rdchk(ADDR_B_LOW, lo);
		// timer mode on counter a: overflow, request, wake, enable
		wr(ADDR_A_VALUE, 8'hfc);
		clr_flags();
		a_en = 1'b1;
		w0 = wakes;
		wr(ADDR_A_CTL, 8'h90);
		wait_a(20);
		@(posedge clk) #1;
		chk({a_irq, 7'h0}, 8'h80);
		chk(8'(wakes - w0), 8'h01);
		a_en = 1'b0;
		@(posedge clk) #1;
		chk({a_irq, 7'h0}, 8'h00);
		rdchk(ADDR_A_CTL, 8'h90);
		wr(ADDR_A_VALUE, 8'hf0);
		rd(ADDR_A_VALUE, r);
		chk({7'h0, r >= 8'hfc}, 8'h01);
		// clear held across the overflow: the set must still win for one cycle
		a_clr = 1'b1;
		@(posedge clk) #1;
		wait_a(12);
		a_clr = 1'b0;
		wr(ADDR_A_CTL, 8'h80);
		rd(ADDR_A_VALUE, r);
		chk({7'h0, r >= 8'hf0 && r <= 8'hf1}, 8'h01);
		// event mode on counter b, rising edges, with wrap-around
		wr(ADDR_B_LOW, 8'hfe);
		wr(ADDR_B_HIGH, 8'hff);
		b_en = 1'b1;
		clr_flags();
		wr(ADDR_B_CTL, 8'h50);
		n = 1 + int'(rnd()) % 6;
		dtc_pin_model_inst.pulses(1, n, 4, 4);
		wr(ADDR_B_CTL, 8'h40);
		exp = ev_model(32'hfffe, 32'hfffe, n, 32'hffff);
		rd_b(exp);
		chk({7'h0, b_flag}, {7'h0, n >= 2});
		chk({7'h0, b_irq}, {7'h0, n >= 2});
		// falling edge selected: a rise must not count, the fall must
		wr(ADDR_B_CTL, 8'h58);
		dtc_pin_model_inst.level(1, 1'b1);
		repeat (6) @(posedge clk);
		#1;
		rd_b(exp);
		dtc_pin_model_inst.level(1, 1'b0);
		repeat (6) @(posedge clk);
		#1;
		exp = ev_model(exp, 32'hfffe, 1, 32'hffff);
		rd_b(exp);
		// pulse width on counter a: a held level must not start it
		wr(ADDR_A_VALUE, 8'h00);
		dtc_pin_model_inst.level(0, 1'b1);
		repeat (8) @(posedge clk);
		#1;
		wr(ADDR_A_CTL, 8'hd0);
		repeat (8) @(posedge clk);
		#1;
		dtc_pin_model_inst.level(0, 1'b0);
		repeat (8) @(posedge clk);
		#1;
		rdchk(ADDR_A_VALUE, 8'h00);
		dtc_pin_model_inst.pulses(0, 1, 40, 8);
		rd(ADDR_A_VALUE, r);
		chk({7'h0, r >= 8'h09 && r <= 8'h0b}, 8'h01);
		rdchk(ADDR_A_CTL, 8'hc0);
		dtc_pin_model_inst.pulses(0, 1, 20, 8);
		rdchk(ADDR_A_VALUE, r);
		stop_test();
	end
endmodule

`default_nettype wire
